// [dv/sbpa_arb_model.sv]
// Purpose: Arbiter and slave model on the far side of the master.
// Assumes: One master, no parking.
// Notes:   Read beat = {address, beat index}; idle data lines toggle.
`timescale 1ns/1ps
`default_nettype none
module sbpa_arb_model (
    input wire logic         sys_clk_i,
    input wire logic         sys_rst_i,
    input wire logic         slow_i,
    input wire logic         retry_i,
    input wire logic         pipe_dis_i,
    input wire logic         abus_req_i,
    input wire logic         ts_i,
    input wire logic [31:0]  addr_i,
    input wire logic         tt_write_i,
    input wire logic         tburst_i,
    input wire logic         dbus_req_i,
    input wire logic [63:0]  data_i,
    output var logic         abus_grant_o,
    output var logic         aack_o,
    output var logic         aretry_o,
    output var logic         dbus_grant_o,
    output var logic [63:0]  data_o,
    output var logic         ta_o
);
    logic [1:0]  beats, bi, cyc;        // Beats left, beat index, slow pacing
    logic        rt_done, dph;          // Retry spent, data phase
    logic [31:0] qa[$];                 // Acked tenures in order
    logic        qw[$], qb[$];
    logic [63:0] wlog[$];               // Write beats seen
    wire [1:0] lim = pipe_dis_i ? 2'h1 : 2'h2;
    wire nta = dph && !(ta_o && beats == 2'h0) && (!slow_i || cyc == 2'h3);
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            {abus_grant_o, aack_o, aretry_o, dbus_grant_o, ta_o, rt_done, dph} <= '0;
            {cyc, beats, bi} <= '0;
            data_o <= 64'h0;
            qa.delete(); qw.delete(); qb.delete();
        end else begin
            cyc <= cyc + 2'h1;
            {abus_grant_o, aack_o, aretry_o, dbus_grant_o} <= 4'h0;
            if (!retry_i) rt_done <= 1'b0;
            if (abus_req_i && !abus_grant_o && qa.size() < lim) abus_grant_o <= 1'b1;
            // owner acks, retry once on demand
            if (ts_i) begin
                aack_o <= 1'b1;
                if (retry_i && !rt_done) begin
                    aretry_o <= 1'b1;
                    rt_done <= 1'b1;
                end else begin
                    qa.push_back(addr_i); qw.push_back(tt_write_i); qb.push_back(tburst_i);
                end
            end
            // data grant independent of address side
            if (!dph && dbus_req_i && !dbus_grant_o && qa.size() != 0) dbus_grant_o <= 1'b1;
            if (dbus_grant_o && dbus_req_i) begin
                dph <= 1'b1;
                beats <= qb[0] ? 2'h3 : 2'h0;
                bi <= 2'h0;
            end
            // terminate every beat, oldest tenure first
            if (ta_o) begin
                if (qw[0]) wlog.push_back(data_i);
                bi <= bi + 2'h1;
                beats <= beats - 2'h1;
                if (beats == 2'h0) begin
                    dph <= 1'b0;
                    void'(qa.pop_front()); void'(qw.pop_front()); void'(qb.pop_front());
                end
            end
            ta_o <= nta;
            data_o <= nta ? {qa[0], 30'h0, ta_o ? bi + 2'h1 : bi} : ~data_o;
        end
    end
endmodule // sbpa_arb_model
`default_nettype wire

// [dv/sbpa_master_monitor.sv]
// Purpose: Port protocol checks for the split-bus master.
// Assumes: Bound to sbpa_master; one clock domain.
// Notes:   Counts acked tenures still waiting for data.
`timescale 1ns/1ps
`default_nettype none
`include "sbpa_consts.vh"
module sbpa_master_monitor #(parameter AW = 32, parameter DW = 64) (
    input wire logic                      sys_clk_i,
    input wire logic                      sys_rst_i,
    input wire logic                      cmd_valid_i,
    input wire logic                      cmd_ready_o,
    input wire logic                      cmd_burst_i,
    input wire logic [`SBPA_CSIZE_W-1:0]  cmd_size_i,
    input wire logic                      cmd_err_o,
    input wire logic                      abus_req_o,
    input wire logic                      abus_grant_i,
    input wire logic                      ts_o,
    input wire logic [AW-1:0]             addr_o,
    input wire logic                      tburst_o,
    input wire logic [`SBPA_TSIZE_W-1:0]  tsize_o,
    input wire logic                      aack_i,
    input wire logic                      aretry_i,
    input wire logic                      dbus_req_o,
    input wire logic                      dbus_grant_i,
    input wire logic [DW-1:0]             data_i,
    input wire logic                      data_oe_n_o,
    input wire logic [DW-1:0]             rd_data_o,
    input wire logic                      rd_valid_o,
    input wire logic                      ta_i,
    input wire logic                      done_o
);
    logic       xfer_q;  // Address transfer phase after ts
    logic [1:0] outs_q;  // Acked tenures awaiting data
    wire a_xfer = ts_o | xfer_q;
    wire acc    = cmd_valid_i & cmd_ready_o;
    wire legal  = cmd_burst_i | (cmd_size_i != 4'h0 && cmd_size_i <= 4'h8);
    wire ok_ack = a_xfer & aack_i & ~aretry_i;
    // Track transfer phase and pipeline fill
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            xfer_q <= 1'b0;
            outs_q <= 2'h0;
        end else begin
            xfer_q <= a_xfer & ~aack_i;
            outs_q <= outs_q + {1'b0, ok_ack} - {1'b0, done_o};
        end
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    property p_req_next; acc && legal |=> abus_req_o; endproperty
    a_req_next: assert property (p_req_next) else $error("no request");
    property p_err_next; acc && !legal |=> cmd_err_o && !abus_req_o; endproperty
    a_err_next: assert property (p_err_next) else $error("bad size kept");
    property p_ts_grant; abus_req_o && abus_grant_i |=> ts_o && !abus_req_o; endproperty
    a_ts_grant: assert property (p_ts_grant) else $error("no ts");
    property p_retry; a_xfer && aack_i && aretry_i |=> abus_req_o && $stable(addr_o); endproperty
    a_retry: assert property (p_retry) else $error("retry lost");
    property p_tsize; ts_o |-> (tburst_o ? tsize_o == 6'h20 : tsize_o inside {[6'h1:6'h8]});
    endproperty
    a_tsize: assert property (p_tsize) else $error("bad tsize");
    property p_oe_grant; $fell(data_oe_n_o) |-> $past(dbus_req_o && dbus_grant_i); endproperty
    a_oe_grant: assert property (p_oe_grant) else $error("drive ungranted");
    property p_rd; rd_valid_o |-> $past(ta_i) && rd_data_o == $past(data_i); endproperty
    a_rd: assert property (p_rd) else $error("bad read beat");
    property p_done; done_o |-> outs_q != 2'h0; endproperty
    a_done: assert property (p_done) else $error("data without ack");
    property p_depth; ts_o |-> outs_q < 2'h2; endproperty
    a_depth: assert property (p_depth) else $error("third address");
    c_ack: cover property (ok_ack);
    c_retry: cover property (a_xfer && aack_i && aretry_i);
    c_full: cover property (outs_q == 2'h2);
endmodule // sbpa_master_monitor
`default_nettype wire

// [dv/sbpa_master_tb.sv]
// Purpose: Self-checking bench for the split-bus master.
// Assumes: Far side is sbpa_arb_model.
// Notes:   Write beats carry a running count.
`timescale 1ns/1ps
`default_nettype none
module sbpa_master_tb;
    logic        sys_clk, sys_rst, cmd_valid, cmd_write, cmd_burst, slow, rty, pdis;
    logic [3:0]  cmd_size;
    logic [31:0] cmd_addr, wn, ts_n, wn_exp;
    logic [64:0] rexp[$];   // Expected {last, read beat}
    logic [63:0] wexp[$];
    int          err_count, samples_checked;
    wire         cmd_ready, cmd_err, wd_take, rd_valid, rd_last, done, abus_req, abus_grant;
    wire         ts, tt_write, tburst, aack, aretry, dbus_req, dbus_grant, data_oe_n, ta;
    wire [5:0]   tsize;
    wire [31:0]  addr;
    wire [63:0]  rd_data, data_m, data_s;
    wire [63:0]  wd_data = {32'hc0de_0000, wn};
    sbpa_master dut (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .cmd_valid_i(cmd_valid),
        .cmd_ready_o(cmd_ready), .cmd_write_i(cmd_write), .cmd_burst_i(cmd_burst),
        .cmd_size_i(cmd_size), .cmd_addr_i(cmd_addr), .cmd_err_o(cmd_err), .wd_data_i(wd_data),
        .wd_take_o(wd_take), .rd_data_o(rd_data), .rd_valid_o(rd_valid), .rd_last_o(rd_last),
        .done_o(done), .abus_req_o(abus_req), .abus_grant_i(abus_grant), .ts_o(ts),
        .addr_o(addr), .tt_write_o(tt_write), .tburst_o(tburst), .tsize_o(tsize),
        .aack_i(aack), .aretry_i(aretry), .dbus_req_o(dbus_req), .dbus_grant_i(dbus_grant),
        .data_i(data_s), .data_o(data_m), .data_oe_n_o(data_oe_n), .ta_i(ta));
    sbpa_arb_model mdl (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .slow_i(slow), .retry_i(rty),
        .pipe_dis_i(pdis), .abus_req_i(abus_req), .ts_i(ts), .addr_i(addr),
        .tt_write_i(tt_write), .tburst_i(tburst), .dbus_req_i(dbus_req), .data_i(data_m),
        .abus_grant_o(abus_grant), .aack_o(aack), .aretry_o(aretry),
        .dbus_grant_o(dbus_grant), .data_o(data_s), .ta_o(ta));
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // Next write beat after each take
    always @(posedge sys_clk) if (wd_take === 1'b1) wn <= #1 wn + 32'h1;
    // Read beats in address order
    always @(negedge sys_clk) begin
        if (rd_valid === 1'b1) chk({rd_last, rd_data}, rexp.size() ? rexp.pop_front() : 65'h0);
        if (ts === 1'b1) ts_n = ts_n + 32'h1;
    end
    task chk(input logic [64:0] g, input logic [64:0] e);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task print_verdict;
        $display("checked=%0d errors=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task issue(input logic w, input logic b, input logic [3:0] sz, input logic [31:0] a);
        int i;
        i = 0;
        while (cmd_ready !== 1'b1 && i < 300) begin @(posedge sys_clk); #1; i++; end
        if (i == 300) begin err_count++; print_verdict; end
        {cmd_valid, cmd_write, cmd_burst, cmd_size, cmd_addr} = {1'b1, w, b, sz, a};
        @(posedge sys_clk); #1 cmd_valid = 1'b0;
        if (!b && (sz == 4'h0 || sz > 4'h8)) begin
            chk(cmd_err, 1'b1);
            @(posedge sys_clk) #1;
        end else begin
            chk({tt_write, tsize, addr}, {w, b ? 6'h20 : {2'h0, sz}, a});
            for (i = 0; i < (b ? 4 : 1); i++)
                if (w) begin wexp.push_back({32'hc0de_0000, wn_exp}); wn_exp++; end
                else rexp.push_back({i == (b ? 3 : 0), a, 30'h0, i[1:0]});
        end
    endtask
    task drain;
        int i;
        for (i = 0; i < 600 && !(rexp.size() == 0 && mdl.qa.size() == 0 && cmd_ready === 1'b1
             && ts !== 1'b1); i++) @(posedge sys_clk);
        #1 if (i == 600) begin err_count++; print_verdict; end
    endtask
    task s_sizes;
        logic [3:0] s;
        for (s = 4'h1; s <= 4'h8; s++) issue(s[0], 1'b0, s, {24'h0, s, 4'h8});
        drain;
    endtask
    task s_retry;
        logic [31:0] n;
        n = ts_n;
        rty = 1'b1;
        issue(1'b0, 1'b0, 4'h4, 32'h0000_4444);
        drain;
        rty = 1'b0;
        chk(ts_n - n, 32'h2);
    endtask
    task s_pipe;
        pdis = 1'b0;
        slow = 1'b1;
        issue(1'b0, 1'b1, 4'h0, 32'h0000_a000);
        issue(1'b1, 1'b1, 4'h0, 32'h0000_b000);
        issue(1'b0, 1'b0, 4'h2, 32'h0000_c000);
        issue(1'b1, 1'b0, 4'h1, 32'h0000_d000);
        drain;
        slow = 1'b0;
    endtask
    task s_wcheck;
        int i;
        chk(mdl.wlog.size(), wexp.size());
        for (i = 0; i < wexp.size() && i < mdl.wlog.size(); i++) chk(mdl.wlog[i], wexp[i]);
    endtask
    initial begin
        {cmd_valid, cmd_write, cmd_burst, cmd_size, cmd_addr} = '0;
        {slow, rty, pdis, sys_rst} = 4'b0011;
        {wn, ts_n, wn_exp, err_count, samples_checked} = '0;
        repeat (16) @(posedge sys_clk);
        #1 sys_rst = 1'b0;
        chk({cmd_ready, data_oe_n, abus_req, dbus_req, ts}, 5'h18);
        issue(1'b0, 1'b0, 4'h8, 32'h1000_0008);
        drain;
        issue(1'b0, 1'b0, 4'h0, 32'h0000_0100);
        issue(1'b0, 1'b0, 4'h9, 32'h0000_0200);
        issue(1'b0, 1'b1, 4'h0, 32'h0000_0300);
        issue(1'b1, 1'b1, 4'h0, 32'h0000_0400);
        drain;
        s_sizes;
        s_retry;
        s_pipe;
        s_wcheck;
        print_verdict;
    end
    initial begin
        #4000000;
        err_count++;
        print_verdict;
    end
endmodule // sbpa_master_tb
bind sbpa_master sbpa_master_monitor #(.AW(AW), .DW(DW)) u_mon (.sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
    .cmd_burst_i(cmd_burst_i), .cmd_size_i(cmd_size_i), .cmd_err_o(cmd_err_o),
    .abus_req_o(abus_req_o), .abus_grant_i(abus_grant_i), .ts_o(ts_o), .addr_o(addr_o),
    .tburst_o(tburst_o), .tsize_o(tsize_o), .aack_i(aack_i), .aretry_i(aretry_i),
    .dbus_req_o(dbus_req_o), .dbus_grant_i(dbus_grant_i), .data_i(data_i),
    .data_oe_n_o(data_oe_n_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .ta_i(ta_i),
    .done_o(done_o));
`default_nettype wire

// [hdl/sbpa_master.v]
// Purpose: Bus master that drives the split-transaction interconnect arbiter.
// Assumes: Arbiter and slaves run on sys_clk_i; sys_rst_i is synchronous.
// Notes:   Address and data tenures run as two machines joined by a queue.
//
// Interconnect rules this block works under
// R1: 32-bit address, 64-bit shared data path
// R2: Address and data tenures run independently
// R3: Arbiter allows two acked tenures outstanding
// R4: Data tenures finish in address order
// R5: Arbiter offers three parking options
// R6: Single 1-8 bytes or 4-beat 32-byte burst
// R7: Eight priority levels, LRU among equals
// R8: Core, DMA, PCI may master everything
// R9: Only owning slave acknowledges the address
// R10: Master runs data tenure after address ack
// R11: Each tenure: arbitrate, transfer, terminate
// R12: Address and data owners may differ
// R13: Address termination is done or retry
// R14: Win data bus before any data tenure
// R15: Sample data on reads, drive on writes
// R16: Every beat terminated; burst ends last beat
// R17: Address pipeline switchable by configuration
// R18: Arbiter acks and regrants before data ends
// R19: Pipeline disable bit 31, reset disabled
// R20: Third grant waits for first tenure done
// R21: No parking: no grant without request
// R22: Retried address tenure is arbitrated again
`timescale 1ns/1ps
`default_nettype none
`include "sbpa_consts.vh"

module sbpa_master #(
    parameter AW     = `SBPA_ADDR_W,
    parameter DW     = `SBPA_DATA_W,
    parameter QDEPTH = `SBPA_PIPE_DEPTH,
    parameter QPTR_W = `SBPA_PIPE_PTR_W
) (
    input  wire                       sys_clk_i,
    input  wire                       sys_rst_i,
    // User command side
    input  wire                       cmd_valid_i,
    output wire                       cmd_ready_o,
    input  wire                       cmd_write_i,
    input  wire                       cmd_burst_i,
    input  wire [`SBPA_CSIZE_W-1:0]   cmd_size_i,
    input  wire [AW-1:0]              cmd_addr_i,
    output wire                       cmd_err_o,
    input  wire [DW-1:0]              wd_data_i,
    output wire                       wd_take_o,
    output wire [DW-1:0]              rd_data_o,
    output wire                       rd_valid_o,
    output wire                       rd_last_o,
    output wire                       done_o,
    // Address tenure pins
    output wire                       abus_req_o,
    input  wire                       abus_grant_i,
    output wire                       ts_o,
    output wire [AW-1:0]              addr_o,
    output wire                       tt_write_o,
    output wire                       tburst_o,
    output wire [`SBPA_TSIZE_W-1:0]   tsize_o,
    input  wire                       aack_i,
    input  wire                       aretry_i,
    // Data tenure pins
    output wire                       dbus_req_o,
    input  wire                       dbus_grant_i,
    input  wire [DW-1:0]              data_i,
    output wire [DW-1:0]              data_o,
    output wire                       data_oe_n_o,
    input  wire                       ta_i
);

    // Legal size check, shared by accept and error paths
    function size_ok;
        input                      burst;
        input [`SBPA_CSIZE_W-1:0]  size;
        begin
            size_ok = burst | ((size >= `SBPA_MIN_BYTES) && (size <= `SBPA_MAX_BYTES));
        end
    endfunction

    // Address machine state
    reg  [1:0]                a_state_q;   // Address tenure phase
    reg  [AW-1:0]             addr_q;      // Address being offered
    reg                       write_q;     // Direction of that address
    reg                       burst_q;     // Burst flag of that address
    reg  [`SBPA_TSIZE_W-1:0]  tsize_q;     // Byte count of that address
    reg                       ts_q;        // Start strobe of address transfer
    reg                       err_q;       // Refused command pulse
    // Data machine state
    reg  [1:0]                d_state_q;   // Data tenure phase
    reg  [`SBPA_BEAT_W-1:0]   beat_q;      // Beat within the tenure
    reg  [DW-1:0]             wdata_q;     // Write data on the bus
    reg                       oe_n_q;      // Data drive enable, low drives
    reg  [DW-1:0]             rdata_q;     // Captured read beat
    reg                       rvalid_q;    // Read beat pulse
    reg                       rlast_q;     // Last read beat flag
    reg                       done_q;      // Data tenure finished pulse
    // Queue wiring
    wire                      q_push;      // Address tenure acked
    wire                      q_pop;       // Oldest data tenure finished
    wire [`SBPA_ENTRY_W-1:0]  q_head;      // Oldest pending tenure
    wire                      q_empty;     // Nothing pending
    wire                      q_full;      // Pipeline slots used up
    wire                      head_wr;     // Oldest is a write
    wire                      head_bu;     // Oldest is a burst
    wire                      last_beat;   // Current beat ends the tenure
    wire                      cmd_take;    // Command accepted this cycle
    wire                      d_start;     // Data bus won this cycle

    // R3: at most two acked tenures wait for data
    assign cmd_ready_o = (a_state_q == `SBPA_A_IDLE) & ~q_full;
    assign cmd_take    = cmd_valid_i & cmd_ready_o;
    assign cmd_err_o   = err_q;

    // R11: address arbitration phase requests the bus
    assign abus_req_o  = (a_state_q == `SBPA_A_REQ);
    assign ts_o        = ts_q;
    // R1: 32-bit address out
    assign addr_o      = addr_q;
    assign tt_write_o  = write_q;
    assign tburst_o    = burst_q;
    assign tsize_o     = tsize_q;

    // R10: acked address becomes a pending data tenure
    assign q_push = (a_state_q == `SBPA_A_XFER) & aack_i & ~aretry_i;

    // Address tenure machine
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            a_state_q <= `SBPA_A_IDLE;
            addr_q    <= {AW{1'b0}};
            write_q   <= 1'b0;
            burst_q   <= 1'b0;
            tsize_q   <= {`SBPA_TSIZE_W{1'b0}};
            ts_q      <= 1'b0;
            err_q     <= 1'b0;
        end else begin
            ts_q  <= 1'b0;
            err_q <= 1'b0;
            case (a_state_q)
                `SBPA_A_IDLE: begin
                    // R6: only single 1-8 bytes or 32-byte bursts
                    if (cmd_take) begin
                        if (size_ok(cmd_burst_i, cmd_size_i)) begin
                            addr_q    <= cmd_addr_i;
                            write_q   <= cmd_write_i;
                            burst_q   <= cmd_burst_i;
                            tsize_q   <= cmd_burst_i ? `SBPA_BURST_BYTES :
                                         {2'h0, cmd_size_i};
                            a_state_q <= `SBPA_A_REQ;
                        end else begin
                            // Illegal size is dropped and flagged
                            err_q <= 1'b1;
                        end
                    end
                end
                `SBPA_A_REQ: begin
                    // Grant starts the address transfer phase
                    if (abus_grant_i) begin
                        ts_q      <= 1'b1;
                        a_state_q <= `SBPA_A_XFER;
                    end
                end
                `SBPA_A_XFER: begin
                    // R9: only owning slave acks
                    // R13: termination is either done or retry
                    if (aack_i) begin
                        if (aretry_i) begin
                            // R22: retry re-arbitrates same tenure
                            a_state_q <= `SBPA_A_REQ;
                        end else begin
                            a_state_q <= `SBPA_A_IDLE;
                        end
                    end
                end
                default: begin
                    a_state_q <= `SBPA_A_IDLE;
                end
            endcase
        end
    end

    // R4: queue keeps data tenures in address order
    sbpa_order_q #(
        .W     (`SBPA_ENTRY_W),
        .DEPTH (QDEPTH),
        .PTR_W (QPTR_W)
    ) u_order_q (
        .sys_clk_i   (sys_clk_i),
        .sys_rst_i   (sys_rst_i),
        .push_i      (q_push),
        .push_data_i ({write_q, burst_q}),
        .pop_i       (q_pop),
        .head_o      (q_head),
        .empty_o     (q_empty),
        .full_o      (q_full)
    );

    assign head_wr = q_head[`SBPA_ENTRY_WR];
    assign head_bu = q_head[`SBPA_ENTRY_BU];

    // R16: single ends at its one beat, burst at fourth
    assign last_beat = ~head_bu | (beat_q == `SBPA_LAST_BEAT);

    // R14: data tenure only after winning the data bus
    assign dbus_req_o = (d_state_q == `SBPA_D_REQ);
    assign d_start    = dbus_req_o & dbus_grant_i;
    assign q_pop      = (d_state_q == `SBPA_D_XFER) & ta_i & last_beat;

    // Next write beat is consumed at grant and at each non-final ack
    assign wd_take_o  = head_wr & (d_start |
                        ((d_state_q == `SBPA_D_XFER) & ta_i & ~last_beat));

    assign data_o      = wdata_q;
    assign data_oe_n_o = oe_n_q;
    assign rd_data_o   = rdata_q;
    assign rd_valid_o  = rvalid_q;
    assign rd_last_o   = rlast_q;
    assign done_o      = done_q;

    // R2: data tenure machine runs apart from the address one
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            d_state_q <= `SBPA_D_IDLE;
            beat_q    <= {`SBPA_BEAT_W{1'b0}};
            wdata_q   <= {DW{1'b0}};
            oe_n_q    <= 1'b1;
            rdata_q   <= {DW{1'b0}};
            rvalid_q  <= 1'b0;
            rlast_q   <= 1'b0;
            done_q    <= 1'b0;
        end else begin
            rvalid_q <= 1'b0;
            rlast_q  <= 1'b0;
            done_q   <= 1'b0;
            case (d_state_q)
                `SBPA_D_IDLE: begin
                    // Oldest acked tenure goes to data arbitration
                    if (~q_empty) begin
                        d_state_q <= `SBPA_D_REQ;
                    end
                end
                `SBPA_D_REQ: begin
                    if (dbus_grant_i) begin
                        beat_q    <= {`SBPA_BEAT_W{1'b0}};
                        d_state_q <= `SBPA_D_XFER;
                        // R15: writes drive the data lines
                        if (head_wr) begin
                            wdata_q <= wd_data_i;
                            oe_n_q  <= 1'b0;
                        end
                    end
                end
                `SBPA_D_XFER: begin
                    // R16: each beat waits for its termination
                    if (ta_i) begin
                        // R15: reads sample the data lines
                        if (~head_wr) begin
                            rdata_q  <= data_i;
                            rvalid_q <= 1'b1;
                            rlast_q  <= last_beat;
                        end
                        if (last_beat) begin
                            oe_n_q    <= 1'b1;
                            done_q    <= 1'b1;
                            d_state_q <= `SBPA_D_IDLE;
                        end else begin
                            beat_q <= beat_q + {{(`SBPA_BEAT_W-1){1'b0}}, 1'b1};
                            if (head_wr) begin
                                wdata_q <= wd_data_i;
                            end
                        end
                    end
                end
                default: begin
                    d_state_q <= `SBPA_D_IDLE;
                end
            endcase
        end
    end

endmodule // sbpa_master
`default_nettype wire

// [hdl/sbpa_order_q.v]
// Purpose: In-order queue of acked address tenures awaiting their data tenure.
// Assumes: DEPTH is a power of two and PTR_W is its log2.
// Notes:   Head entry is the oldest tenure; pop only when its data is done.
`timescale 1ns/1ps
`default_nettype none
`include "sbpa_consts.vh"

module sbpa_order_q #(
    parameter W     = `SBPA_ENTRY_W,
    parameter DEPTH = `SBPA_PIPE_DEPTH,
    parameter PTR_W = `SBPA_PIPE_PTR_W
) (
    input  wire             sys_clk_i,
    input  wire             sys_rst_i,
    input  wire             push_i,
    input  wire [W-1:0]     push_data_i,
    input  wire             pop_i,
    output wire [W-1:0]     head_o,
    output wire             empty_o,
    output wire             full_o
);

    reg  [W-1:0]     mem_q [0:DEPTH-1];  // Entry storage
    reg  [PTR_W-1:0] wptr_q;             // Next slot to fill
    reg  [PTR_W-1:0] rptr_q;             // Oldest entry
    reg  [PTR_W:0]   count_q;            // Entries held
    wire             do_push;            // Accepted push
    wire             do_pop;             // Accepted pop

    // Guard against over- and underflow
    assign do_push = push_i & ~full_o;
    assign do_pop  = pop_i & ~empty_o;
    assign empty_o = (count_q == {(PTR_W+1){1'b0}});
    assign full_o  = (count_q == DEPTH[PTR_W:0]);
    assign head_o  = mem_q[rptr_q];

    // Storage write; no reset needed, count guards reads
    always @(posedge sys_clk_i) begin
        if (do_push) begin
            mem_q[wptr_q] <= push_data_i;
        end
    end

    // Pointers and occupancy
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            wptr_q  <= {PTR_W{1'b0}};
            rptr_q  <= {PTR_W{1'b0}};
            count_q <= {(PTR_W+1){1'b0}};
        end else begin
            if (do_push) begin
                wptr_q <= wptr_q + {{(PTR_W-1){1'b0}}, 1'b1};
            end
            if (do_pop) begin
                rptr_q <= rptr_q + {{(PTR_W-1){1'b0}}, 1'b1};
            end
            // Simultaneous push and pop keeps the count
            if (do_push & ~do_pop) begin
                count_q <= count_q + {{PTR_W{1'b0}}, 1'b1};
            end else if (do_pop & ~do_push) begin
                count_q <= count_q - {{PTR_W{1'b0}}, 1'b1};
            end
        end
    end

endmodule // sbpa_order_q
`default_nettype wire

// [shared/sbpa_consts.vh]
// Purpose: Shared constants for the split-bus pipeline master.
// Assumes: Included by bare name from every design file that needs it.
// Notes:   Widths, beat counts, pipeline depth and state codes live here.
`ifndef SBPA_CONSTS_VH
`define SBPA_CONSTS_VH

// Physical address width on the interconnect
`define SBPA_ADDR_W      32
// Shared data path width
`define SBPA_DATA_W      64
// Width of the transfer size field in bytes (holds 1..8 and 32)
`define SBPA_TSIZE_W     6
// Width of the user size request
`define SBPA_CSIZE_W     4
// Smallest and largest single-beat transfer in bytes
`define SBPA_MIN_BYTES   4'h1
`define SBPA_MAX_BYTES   4'h8
// Burst length in bytes and its beat counter
`define SBPA_BURST_BYTES 6'h20
`define SBPA_BEAT_W      2
`define SBPA_LAST_BEAT   2'h3
// Acked address tenures that may wait for their data tenure
`define SBPA_PIPE_DEPTH  2
`define SBPA_PIPE_PTR_W  1
// Entry kept per acked tenure: {write, burst}
`define SBPA_ENTRY_W     2
`define SBPA_ENTRY_WR    1
`define SBPA_ENTRY_BU    0

// Address tenure states
`define SBPA_A_IDLE      2'h0
`define SBPA_A_REQ       2'h1
`define SBPA_A_XFER      2'h2
// Data tenure states
`define SBPA_D_IDLE      2'h0
`define SBPA_D_REQ       2'h1
`define SBPA_D_XFER      2'h2

`endif
